// ---- rtl/flash_ctl_pkg.sv ----
package flash_ctl_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_ID = 8'h10;

  // Control register fields
  localparam int MODE_LSB = 4;
  localparam logic [3:0] MODE_ENABLE = 4'h3;
  localparam logic [3:0] MODE_LOCK = 4'hC;
  localparam logic [3:0] MODE_RESET = 4'hC;
  localparam int BANK_BIT = 3;

  // Unlock command sequence
  localparam logic [15:0] UNLOCK_ADDR_A = 16'hF555;
  localparam logic [15:0] UNLOCK_ADDR_B = 16'hFAAA;
  localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Flash map: 1000H..FFFFH, 4 KB sectors
  localparam logic [15:0] FLASH_BASE = 16'h1000;
  localparam int SECTOR_BITS = 12;
  localparam int ARRAY_WORDS = 65536;

  // Serial programming mode
  localparam logic [15:0] LOADER_BASE = 16'h7800;
  localparam logic [15:0] LOADER_LAST = 16'h7FFF;
  localparam int LOADER_BYTES = 2048;
  localparam logic [7:0] MATCH_BYTE = 8'h5A;
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int BAUD_CYCLES = CLK_HZ / BAUD_DEFAULT;

  // Program and erase busy times
  localparam int PROG_TIME_US = 40;
  localparam int ERASE_TIME_US = 30000;
  localparam int PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1000000);
  localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * (CLK_HZ / 1000000);

  localparam logic [7:0] PRODUCT_ID = 8'h42; // Arbitrary value

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } flash_wr_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_PROG,
    OP_ERASE
  } flash_op_t;

endpackage : flash_ctl_pkg

// ---- rtl/cmd_sequencer.sv ----
module cmd_sequencer
  import flash_ctl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic wr_valid,
  input wire flash_wr_t wr,
  output logic op_start,
  output flash_op_t op_kind,
  output flash_wr_t op_target
);

  typedef enum {
    S_IDLE, S_U1, S_U2, S_ERASE1, S_ERASE2, S_ERASE3, S_PROG
  } seq_state_t;

  seq_state_t state_q, state_d;

  wire is_a_aa = (wr.addr == UNLOCK_ADDR_A) && (wr.data == UNLOCK_DATA_A);
  wire is_b_55 = (wr.addr == UNLOCK_ADDR_B) && (wr.data == UNLOCK_DATA_B);
  wire is_a_80 = (wr.addr == UNLOCK_ADDR_A) && (wr.data == CMD_ERASE_SETUP);
  wire is_a_a0 = (wr.addr == UNLOCK_ADDR_A) && (wr.data == CMD_PROGRAM);
  wire is_erase = (wr.data == CMD_SECTOR_ERASE);

  always_comb begin
    state_d = state_q;
    if (wr_valid) begin
      // Any wrong write aborts back to idle
      case (state_q)
        S_IDLE: state_d = is_a_aa ? S_U1 : S_IDLE;
        S_U1: state_d = is_b_55 ? S_U2 : S_IDLE;
        S_U2: state_d = is_a_80 ? S_ERASE1 : (is_a_a0 ? S_PROG : S_IDLE);
        S_ERASE1: state_d = is_a_aa ? S_ERASE2 : S_IDLE;
        S_ERASE2: state_d = is_b_55 ? S_ERASE3 : S_IDLE;
        S_ERASE3: state_d = S_IDLE;
        S_PROG: state_d = S_IDLE;
        default: state_d = S_IDLE;
      endcase
    end
    if (!enable) begin
      state_d = S_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      op_start <= 1'b0;
      op_kind <= OP_NONE;
      op_target <= '0;
    end else begin
      state_q <= state_d;
      op_start <= 1'b0;
      if (enable && wr_valid && state_q == S_ERASE3 && is_erase) begin
        op_start <= 1'b1;
        op_kind <= OP_ERASE;
        op_target <= wr;
      end else if (enable && wr_valid && state_q == S_PROG) begin
        op_start <= 1'b1;
        op_kind <= OP_PROG;
        op_target <= wr;
      end
    end
  end

endmodule : cmd_sequencer

// ---- rtl/match_receiver.sv ----
module match_receiver
  import flash_ctl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic active,
  input wire logic rx_sync,
  output logic matched
);

  // Plain 8N1 receiver at the default rate, start centred sampling
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic busy_q;

  wire bit_end = (cnt_q == 16'(BAUD_CYCLES - 1));
  wire half_end = (cnt_q == 16'(BAUD_CYCLES / 2 - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      bit_q <= '0;
      shift_q <= '0;
      busy_q <= 1'b0;
      matched <= 1'b0;
    end else if (!active) begin
      busy_q <= 1'b0;
      matched <= 1'b0;
    end else if (!busy_q) begin
      cnt_q <= '0;
      bit_q <= '0;
      busy_q <= !rx_sync;
    end else if ((bit_q == 4'd0) ? half_end : bit_end) begin
      cnt_q <= '0;
      bit_q <= bit_q + 4'd1;
      if (bit_q == 4'd0 && rx_sync) begin
        busy_q <= 1'b0;
      end else if (bit_q == 4'd9) begin
        busy_q <= 1'b0;
        if (rx_sync && shift_q == MATCH_BYTE) begin
          matched <= 1'b1;
        end
      end else if (bit_q != 4'd0) begin
        shift_q <= {rx_sync, shift_q[7:1]};
      end
    end else begin
      cnt_q <= cnt_q + 16'd1;
    end
  end

endmodule : match_receiver

// ---- rtl/flash_program_mode_control.sv ----
// Function
// - Accept command sequences only with mode 0011B
// - Mode 1100B blocks further command sequences
// - Six-write unlock sequence starts sector erase
// - Four-write unlock sequence programs one byte
// - Completion is two identical consecutive reads
// - Byte program reaches whole map, no bank
// - Sector erase clears aligned 4 KB range
// - Non-maskable fetch during busy is undefined
// - Serial mode maps 2 KB loader ROM
// - Serial mode: pins become UART, ports float
// - Loader write translates normal addresses internally; no loader write is modelled here
// - Serial mode offers seven loader operations; only the match flag is modelled here
// - Serial link defaults to 9600 bps
// - Wait for matching byte before commands
module flash_program_mode_control
  import flash_ctl_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic test_pin,
  input wire logic port0_line1,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic ports_hiz,
  output logic serial_mode,
  output logic loader_rom_mapped,
  output logic flash_busy
);

  // Register map: CTRL holds mode field and bank bit; ADDR/DATA form a
  // flash window: writing DATA issues a flash bus write, reading DATA
  // performs a flash read at ADDR.

  // Strap synchronisers run through reset so the strap is settled at release
  logic test_s1_q, test_s2_q, boot_s1_q, boot_s2_q;
  always_ff @(posedge hclk) begin
    test_s1_q <= test_pin;
    test_s2_q <= test_s1_q;
    boot_s1_q <= port0_line1;
    boot_s2_q <= boot_s1_q;
  end

  // Strap captured once, on the first edge after reset release
  logic strap_done_q, serial_mode_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      serial_mode_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      serial_mode_q <= test_s2_q & boot_s2_q;
    end
  end

  // AHB-Lite address phase capture
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  wire take = hsel && hready && htrans[1];
  wire [7:0] offs = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
    end else if (hready) begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      addr_q <= offs;
    end
  end

  // Registers
  logic [3:0] mode_q;
  logic bank_q;
  logic [15:0] faddr_q;
  wire cmd_enable = (mode_q == MODE_ENABLE);
  wire wr_ctrl = wr_pend_q && addr_q == OFF_CTRL;
  wire wr_addr = wr_pend_q && addr_q == OFF_ADDR;
  wire wr_data = wr_pend_q && addr_q == OFF_DATA;
  wire rd_data = rd_pend_q && addr_q == OFF_DATA;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= MODE_RESET;
      bank_q <= 1'b0;
      faddr_q <= '0;
    end else begin
      if (wr_ctrl) begin
        mode_q <= hwdata[MODE_LSB +: 4];
        bank_q <= hwdata[BANK_BIT];
      end
      if (wr_addr) begin
        faddr_q <= hwdata[15:0];
      end
    end
  end

  // Command sequencer
  logic op_start;
  flash_op_t op_kind;
  flash_wr_t op_target;
  flash_wr_t cur_wr;
  assign cur_wr = '{addr: faddr_q, data: hwdata[7:0]};

  cmd_sequencer u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(cmd_enable && !flash_busy),
    .wr_valid(wr_data),
    .wr(cur_wr),
    .op_start(op_start),
    .op_kind(op_kind),
    .op_target(op_target)
  );

  // Flash array model, byte wide, full map without bank selection
  logic [7:0] array_q [ARRAY_WORDS];
  logic [31:0] busy_cnt_q;
  logic busy_q, toggle_q;
  flash_op_t cur_op_q;
  flash_wr_t tgt_q;
  logic [SECTOR_BITS:0] erase_idx_q;

  function automatic logic [15:0] sector_addr(input logic [15:0] a,
                                              input logic [SECTOR_BITS-1:0] i);
    sector_addr = {a[15:SECTOR_BITS], i};
  endfunction : sector_addr

  wire busy_done = (busy_cnt_q == 32'd0);
  wire erase_walk = busy_q && cur_op_q == OP_ERASE && !erase_idx_q[SECTOR_BITS];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
      cur_op_q <= OP_NONE;
      tgt_q <= '0;
      erase_idx_q <= '0;
      toggle_q <= 1'b0;
    end else if (op_start) begin
      busy_q <= 1'b1;
      cur_op_q <= op_kind;
      tgt_q <= op_target;
      erase_idx_q <= '0;
      busy_cnt_q <= (op_kind == OP_ERASE) ? 32'(ERASE_CYCLES) : 32'(PROG_CYCLES);
    end else if (busy_q) begin
      if (rd_data) begin
        toggle_q <= !toggle_q;
      end
      if (erase_walk) begin
        erase_idx_q <= erase_idx_q + 1'b1;
      end
      if (busy_done && !erase_walk) begin
        busy_q <= 1'b0;
        cur_op_q <= OP_NONE;
      end else if (!busy_done) begin
        busy_cnt_q <= busy_cnt_q - 32'd1;
      end
    end
  end

  // Array writes; a program can only clear bits, like real flash
  always_ff @(posedge hclk) begin
    if (erase_walk) begin
      array_q[sector_addr(tgt_q.addr, erase_idx_q[SECTOR_BITS-1:0])] <= ERASED_BYTE;
    end else if (busy_q && busy_done && cur_op_q == OP_PROG) begin
      // Normal-mode address indexes the array directly, no bank step
      array_q[tgt_q.addr] <= array_q[tgt_q.addr] & tgt_q.data;
    end
  end

  // Read path: busy reads toggle bit 6 so two reads differ; an
  // interrupt vector fetch during busy gets this same junk.
  wire [7:0] array_rd = array_q[faddr_q];
  wire [7:0] status_rd = {1'b0, toggle_q, 6'h00};
  wire [7:0] flash_rd = busy_q ? status_rd : array_rd;
  wire in_loader = serial_mode_q && faddr_q >= LOADER_BASE
                   && faddr_q <= LOADER_LAST;

  // Serial mode
  logic rx_s1_q, rx_s2_q, matched;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= port0_line1;
      rx_s2_q <= rx_s1_q;
    end
  end

  match_receiver u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .active(serial_mode_q),
    .rx_sync(rx_s2_q),
    .matched(matched)
  );
  // Loader operations are not modelled; the match flag only feeds STAT

  // Read mux, decoded in the address phase so data stands in the data phase.
  // Limitation: a read right behind an ADDR write sees the old flash address.
  logic [31:0] rdata_mux;
  always_comb begin
    case (offs)
      OFF_CTRL: rdata_mux = {24'h0, mode_q, bank_q, 3'h0};
      OFF_ADDR: rdata_mux = {16'h0, faddr_q};
      OFF_DATA: rdata_mux = {24'h0, in_loader ? 8'h00 : flash_rd};
      OFF_STAT: rdata_mux = {28'h0, matched, serial_mode_q, cmd_enable, busy_q};
      OFF_ID: rdata_mux = {24'h0, PRODUCT_ID};
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b0;
      ports_hiz <= 1'b0;
      serial_mode <= 1'b0;
      loader_rom_mapped <= 1'b0;
      flash_busy <= 1'b0;
    end else begin
      if (take && !hwrite) begin
        hrdata <= rdata_mux;
      end
      serial_out_pin <= 1'b1;
      serial_out_oe <= serial_mode_q;
      ports_hiz <= serial_mode_q;
      serial_mode <= serial_mode_q;
      loader_rom_mapped <= serial_mode_q;
      flash_busy <= busy_q || op_start;
    end
  end

endmodule : flash_program_mode_control

// ---- test/flash_ctl_asserts.sv ----
module flash_ctl_asserts
  import flash_ctl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic ports_hiz,
  input wire logic serial_mode,
  input wire logic loader_rom_mapped,
  input wire logic flash_busy
);
  logic [15:0] busy_q;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Length of the current busy stretch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      busy_q <= '0;
    else
      busy_q <= flash_busy ? busy_q + 16'h1 : '0;
  end
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
  property p_loader;
    loader_rom_mapped == serial_mode;
  endproperty
  a_loader: assert property (p_loader)
    else $error("loader map differs from serial mode");
  property p_hiz;
    ports_hiz == serial_mode && serial_out_oe == serial_mode;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("port float or output enable wrong");
  property p_tx_idle;
    !serial_mode |-> serial_out_pin;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("serial output not idle high");
  property p_held;
    serial_mode |=> serial_mode [*8];
  endproperty
  a_held: assert property (p_held)
    else $error("serial mode dropped without reset");
  property p_busy_len;
    $fell(flash_busy) |-> busy_q >= PROG_CYCLES - 2;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy stretch too short");
  property p_rd_hold;
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_no_busy_serial;
    serial_mode |-> !flash_busy;
  endproperty
  a_no_busy_serial: assert property (p_no_busy_serial)
    else $error("busy while in serial mode");
endmodule : flash_ctl_asserts

bind flash_program_mode_control flash_ctl_asserts i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .ports_hiz(ports_hiz), .serial_mode(serial_mode),
  .loader_rom_mapped(loader_rom_mapped), .flash_busy(flash_busy)
);

// ---- test/serial_writer.sv ----
module serial_writer
  import flash_ctl_pkg::*;
(
  input wire logic hclk,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic line,
  output logic sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] frame;
  initial begin
    line = 1'b1; // Idle mark doubles as the strap level
    sent = 1'b0;
    @(posedge hclk iff go);
    frame = {1'b1, tx_byte, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= frame[i]; // LSB first at the default rate
      repeat (BAUD_CYCLES) @(posedge hclk);
    end
    sent <= 1'b1;
  end
endmodule : serial_writer

// ---- test/flash_program_mode_control_bench.sv ----
module flash_program_mode_control_bench
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic hclk, hresetn, hsel, hwrite, test_pin, go;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, tx, tx_oe, hiz, smode, lmap, busy, sent;
  wire line;
  logic [7:0] a, b;
  int failures, checks, cyc;
  row_t rows[10];
  logic [15:0] prog_at[2] = '{16'h1000, 16'hFFFF};

  flash_program_mode_control #(.ERASE_CYCLES(100)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .test_pin(test_pin),
    .port0_line1(line), .serial_out_pin(tx), .serial_out_oe(tx_oe), .ports_hiz(hiz),
    .serial_mode(smode), .loader_rom_mapped(lmap), .flash_busy(busy)
  );
  serial_writer i_writer (
    .hclk(hclk), .go(go), .tx_byte(MATCH_BYTE), .line(line), .sent(sent)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task summarize;
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Address phase held until hready, then data phase until hready
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task fw(input logic [15:0] ad, input logic [7:0] d);
    bus(1'b1, OFF_ADDR, {16'h0, ad});
    bus(1'b1, OFF_DATA, {24'h0, d});
  endtask : fw

  task frd(input logic [15:0] ad, input logic [7:0] e);
    bus(1'b1, OFF_ADDR, {16'h0, ad});
    bus(1'b0, OFF_DATA, 32'h0);
    chk("flash byte", rd[7:0], e);
  endtask : frd

  task cmd(input logic erase, input logic [15:0] t, input logic [7:0] d);
    fw(UNLOCK_ADDR_A, UNLOCK_DATA_A);
    fw(UNLOCK_ADDR_B, UNLOCK_DATA_B);
    if (erase) begin
      fw(UNLOCK_ADDR_A, CMD_ERASE_SETUP);
      fw(UNLOCK_ADDR_A, UNLOCK_DATA_A);
      fw(UNLOCK_ADDR_B, UNLOCK_DATA_B);
      fw(t, CMD_SECTOR_ERASE);
    end else begin
      fw(UNLOCK_ADDR_A, CMD_PROGRAM);
      fw(t, d);
    end
  endtask : cmd

  // Busy reads must toggle, then settle to two equal reads
  task op(input logic erase, input logic [15:0] t, input logic [7:0] d);
    cmd(erase, t, d);
    bus(1'b1, OFF_ADDR, {16'h0, t});
    bus(1'b0, OFF_DATA, 32'h0);
    b = rd[7:0];
    bus(1'b0, OFF_DATA, 32'h0);
    chk("busy toggle", {31'h0, rd[7:0] != b}, 32'h1);
    do begin
      a = rd[7:0];
      bus(1'b0, OFF_DATA, 32'h0);
    end while (rd[7:0] !== a);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("busy after poll", rd[0], 1'b0);
  endtask : op

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, test_pin, go} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    rows = '{'{0, OFF_CTRL, 0, {MODE_RESET, 4'h0}}, '{0, OFF_ID, 0, PRODUCT_ID},
      '{0, OFF_STAT, 0, 8'h00}, '{1, 8'h20, 8'hFF, 0}, '{0, 8'h20, 0, 8'h00},
      '{1, OFF_CTRL, 8'h38, 0}, '{0, OFF_CTRL, 0, 8'h38}, '{0, OFF_STAT, 0, 8'h02},
      '{1, OFF_CTRL, 8'hC8, 0}, '{0, OFF_STAT, 0, 8'h00}};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("serial mode off", smode, 1'b0);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, {24'h0, rows[i].d});
      if (!rows[i].w)
        chk("register", rd[7:0], rows[i].e);
    end
    cmd(1'b0, 16'hE000, 8'h00);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("locked busy", rd[0], 1'b0);
    // Interrupts off, timer stopped, RAM code: host side only
    bus(1'b1, OFF_CTRL, {24'h0, MODE_ENABLE, 4'h8});
    op(1'b1, 16'hE000, 8'h00);
    frd(16'hE000, ERASED_BYTE);
    frd(16'hEFFF, ERASED_BYTE);
    op(1'b0, 16'hE000, 8'h3F);
    frd(16'hE000, 8'h3F);
    foreach (prog_at[i]) begin
      op(1'b0, prog_at[i], 8'h00);
      frd(prog_at[i], 8'h00);
    end
    // Broken unlock: third write is data, not a command
    fw(UNLOCK_ADDR_A, UNLOCK_DATA_A);
    fw(UNLOCK_ADDR_B, UNLOCK_DATA_B);
    fw(16'hE001, 8'h00);
    frd(16'hE001, ERASED_BYTE);
    bus(1'b1, OFF_CTRL, {24'h0, MODE_LOCK, 4'h8});
    cmd(1'b0, 16'hE002, 8'h00);
    frd(16'hE002, ERASED_BYTE);
    @(posedge hclk);
    hresetn <= 1'b0;
    test_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("serial pins", {smode, lmap, hiz, tx_oe}, 4'hF);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("no match yet", rd[3:0], 4'h4);
    go <= 1'b1;
    @(posedge sent);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("matched", rd[3:0], 4'hC);
    summarize();
  end
endmodule : flash_program_mode_control_bench
